/* File: rtl/gpp_pkg.sv */
package gpp_pkg;

  localparam int GPP_ADDR_W = 8;
  localparam int GPP_MODE_W = 2;
  localparam int GPP_FEXT_W = 3;

  localparam logic [GPP_ADDR_W-1:0] GPP_OFS_MODE = 8'h00;
  localparam logic [GPP_ADDR_W-1:0] GPP_OFS_DOUT = 8'h04;
  localparam logic [GPP_ADDR_W-1:0] GPP_OFS_PIN  = 8'h08;
  localparam logic [GPP_ADDR_W-1:0] GPP_OFS_ALT  = 8'h0c;
  localparam logic [GPP_ADDR_W-1:0] GPP_OFS_DRV  = 8'h10;
  localparam logic [GPP_ADDR_W-1:0] GPP_OFS_FEXT = 8'h14;
  localparam logic [GPP_ADDR_W-1:0] GPP_OFS_STAT = 8'h18;

  localparam int       GPP_STAT_ROLE_BIT  = 0;
  localparam int       GPP_HTRANS_ACT_BIT = 1;
  localparam logic [2:0] GPP_HSIZE_WORD   = 3'h2;
  localparam logic [1:0] GPP_HRESP_OKAY   = 2'h0;

  // pin direction modes, field value 0..3 in this order
  typedef enum logic [GPP_MODE_W-1:0] {
    GPP_IN,
    GPP_OUT,
    GPP_BIDIR,
    GPP_OD
  } gpp_mode_t;

endpackage

/* File: rtl/gpp_pin_cell.sv */
`timescale 1ns/1ns
module gpp_pin_cell (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire gpp_pkg::gpp_mode_t mode,
  input  wire logic              dout,
  input  wire logic              drv,
  input  wire logic              alt_en,
  input  wire logic              alt_val,
  input  wire logic              active,
  output logic                   pad_o,
  output logic                   pad_oe
);
  import gpp_pkg::*;

  typedef struct packed {
    logic o;
    logic oe;
  } gpp_cell_t;

  gpp_cell_t st;
  gpp_cell_t next_st;

  always_comb begin
    next_st = '0;
    if (active) begin
      if (alt_en) begin
        next_st.o  = alt_val;
        next_st.oe = 1'b1;
      end else begin
        unique case (mode)
          GPP_IN: begin
            next_st.oe = 1'b0;
          end
          GPP_OUT: begin
            next_st.o  = dout;
            next_st.oe = 1'b1;
          end
          GPP_BIDIR: begin
            next_st.o  = dout;
            next_st.oe = drv;
          end
          GPP_OD: begin
            // never drive high: the board pull-up makes the one
            next_st.o  = 1'b0;
            next_st.oe = ~dout;
          end
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pad_o  = st.o;
  assign pad_oe = st.oe;

endmodule

/* File: rtl/gpp_port.sv */
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
// Behaviour
// - each pin selects input, push-pull output, bidirectional or open-drain
// - after reset every pin is input with its driver off
// - a selected alternative function takes the pin over from plain use
// - pins 0 to 3 choose between general bit n and pulse output n
// - pins 4 to 8 are general bits only, no pulse function
// - two pins drive flash address extension bits 24 and 25
// - a third pin drives flash address extension bit 26
// - as secondary controller the general and pulse pins are unused
// - role pin high means primary, low means secondary
module gpp_port #(
  parameter int NUM_PINS = 9,
  parameter int NUM_PWM  = 4
) (
  input  wire logic                           hclk,
  input  wire logic                           hresetn,
  input  wire logic                           hsel,
  input  wire logic [31:0]                    haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [31:0]                    hwdata,
  input  wire logic                           hready,
  output logic                                hreadyout,
  output logic [31:0]                         hrdata,
  output logic [1:0]                          hresp,
  input  wire logic                           role_select_pin,
  input  wire logic [NUM_PWM-1:0]             pwm_in,
  input  wire logic [NUM_PINS-1:0]            gpio_i,
  output logic [NUM_PINS-1:0]                 gpio_o,
  output logic [NUM_PINS-1:0]                 gpio_oe,
  output logic [gpp_pkg::GPP_FEXT_W-1:0]      flash_addr_ext
);
  import gpp_pkg::*;

  if (NUM_PWM > NUM_PINS || NUM_PINS * GPP_MODE_W > 32 || NUM_PWM < 1) begin : g_bad
    $error("gpp_port: pin or pulse channel count out of range");
  end

  typedef struct packed {
    logic [NUM_PINS*GPP_MODE_W-1:0] mode;
    logic [NUM_PINS-1:0]            dout;
    logic [NUM_PINS-1:0]            drv;
    logic [NUM_PINS-1:0]            pin_in;
    logic [NUM_PWM-1:0]             alt;
    logic [GPP_FEXT_W-1:0]          fext;
    logic                           role;
    logic                           wr_pend;
    logic [GPP_ADDR_W-1:0]          wr_addr;
    logic [31:0]                    rdata;
    logic                           ready;
  } gpp_state_t;

  gpp_state_t st;
  gpp_state_t next_st;
  logic       take;

  function automatic logic [31:0] rd_word(input logic [GPP_ADDR_W-1:0] a,
                                          input gpp_state_t s);
    logic [31:0] w;
    w = '0;
    case (a)
      GPP_OFS_MODE: w[NUM_PINS*GPP_MODE_W-1:0] = s.mode;
      GPP_OFS_DOUT: w[NUM_PINS-1:0] = s.dout;
      GPP_OFS_PIN:  w[NUM_PINS-1:0] = s.pin_in;
      GPP_OFS_ALT:  w[NUM_PWM-1:0] = s.alt;
      GPP_OFS_DRV:  w[NUM_PINS-1:0] = s.drv;
      GPP_OFS_FEXT: w[GPP_FEXT_W-1:0] = s.fext;
      GPP_OFS_STAT: w[GPP_STAT_ROLE_BIT] = s.role;
      default:      w = '0;
    endcase
    return w;
  endfunction

  always_comb begin
    next_st        = st;
    next_st.ready  = 1'b1;
    next_st.pin_in = gpio_i;
    next_st.role   = role_select_pin;
    if (st.wr_pend) begin
      case (st.wr_addr)
        GPP_OFS_MODE: next_st.mode = hwdata[NUM_PINS*GPP_MODE_W-1:0];
        GPP_OFS_DOUT: next_st.dout = hwdata[NUM_PINS-1:0];
        GPP_OFS_ALT:  next_st.alt  = hwdata[NUM_PWM-1:0];
        GPP_OFS_DRV:  next_st.drv  = hwdata[NUM_PINS-1:0];
        GPP_OFS_FEXT: next_st.fext = hwdata[GPP_FEXT_W-1:0];
        default: begin
        end
      endcase
    end
    take = hsel && hready && htrans[GPP_HTRANS_ACT_BIT] && (hsize == GPP_HSIZE_WORD);
    next_st.wr_pend = take && hwrite;
    next_st.wr_addr = haddr[GPP_ADDR_W-1:0];
    // read from the updated copy so a read right behind a write sees it
    next_st.rdata = (take && !hwrite) ? rd_word(haddr[GPP_ADDR_W-1:0], next_st) : '0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st       <= '0;
      st.ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout      = st.ready;
  assign hrdata         = st.rdata;
  assign flash_addr_ext = st.fext;

  // hresp is constant OKAY but still held in a flop
  logic [1:0] resp_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resp_q <= GPP_HRESP_OKAY;
    end else begin
      resp_q <= GPP_HRESP_OKAY;
    end
  end
  assign hresp = resp_q;

  default clocking gpp_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    gpp_mode_t pm;
    logic      a_en;
    logic      a_val;

    assign pm = gpp_mode_t'(st.mode[i*GPP_MODE_W +: GPP_MODE_W]);

    if (i < NUM_PWM) begin : g_alt
      assign a_en  = st.alt[i];
      assign a_val = pwm_in[i];
      AST_ALT_TAKES_PIN: assert property (
        (st.role && a_en) |=> (gpio_oe[i] && gpio_o[i] == $past(pwm_in[i])))
        else $error("pulse channel not on its pin");
    end else begin : g_plain
      // no pulse channel exists here, whatever is written to the alt register
      assign a_en  = 1'b0;
      assign a_val = 1'b0;
      AST_PLAIN_ONLY: assert property (
        (st.role && pm == GPP_OUT) |=> (gpio_oe[i] && gpio_o[i] == $past(st.dout[i])))
        else $error("general-only pin not following its output bit");
    end

    gpp_pin_cell u_cell (
      .hclk    (hclk),
      .hresetn (hresetn),
      .mode    (pm),
      .dout    (st.dout[i]),
      .drv     (st.drv[i]),
      .alt_en  (a_en),
      .alt_val (a_val),
      .active  (st.role),
      .pad_o   (gpio_o[i]),
      .pad_oe  (gpio_oe[i])
    );

    AST_INPUT_RELEASED: assert property (
      (pm == GPP_IN && !a_en) |=> !gpio_oe[i])
      else $error("input pin is driving");
    AST_PUSH_PULL: assert property (
      (st.role && !a_en && pm == GPP_OUT) |=> (gpio_oe[i] && gpio_o[i] == $past(st.dout[i])))
      else $error("push-pull pin wrong");
    AST_BIDIR_DRIVE: assert property (
      (st.role && !a_en && pm == GPP_BIDIR) |=> (gpio_oe[i] == $past(st.drv[i])))
      else $error("bidirectional enable wrong");
    AST_OPEN_DRAIN: assert property (
      (st.role && !a_en && pm == GPP_OD) |=> (!gpio_o[i] && gpio_oe[i] == !$past(st.dout[i])))
      else $error("open-drain pin drove high or wrong enable");
    AST_SECONDARY_IDLE: assert property (
      !st.role |=> !gpio_oe[i])
      else $error("pin driven on secondary controller");
  end

  AST_ROLE_LOW_IDLES: assert property (
    !role_select_pin |=> ##1 (gpio_oe == '0))
    else $error("secondary role did not release pins");
  AST_FLASH_EXT_WRITE: assert property (
    (take && hwrite && haddr[GPP_ADDR_W-1:0] == GPP_OFS_FEXT)
      |=> ##1 (flash_addr_ext == $past(hwdata[GPP_FEXT_W-1:0])))
    else $error("flash extension bits not written");
  // the upper flash address must not wander between writes, whatever the role
  AST_FLASH_EXT_HOLD: assert property (
    !(st.wr_pend && st.wr_addr == GPP_OFS_FEXT) |=> $stable(flash_addr_ext))
    else $error("flash extension bits changed without a write");
  AST_ZERO_WAIT: assert property (
    hreadyout && hresp == GPP_HRESP_OKAY)
    else $error("slave stalled or errored");

  COV_PWM_PIN0:  cover property (st.role && st.alt[0] ##1 gpio_oe[0]);
  // last pin always exists, whatever the pin count
  COV_OD_LOW:    cover property (g_pin[NUM_PINS-1].pm == GPP_OD && !st.dout[NUM_PINS-1]
                                 && st.role ##1 gpio_oe[NUM_PINS-1]);
  COV_SECONDARY: cover property (!st.role ##1 !st.role);
  COV_FEXT_WR:   cover property (take && hwrite && haddr[GPP_ADDR_W-1:0] == GPP_OFS_FEXT);

endmodule

/* File: verification/gpp_board.sv */
`timescale 1ns/1ns
module gpp_board (
  input  wire logic [8:0] pin_o,
  input  wire logic [8:0] pin_oe,
  output logic      [8:0] pin_i
);
  // every pin has a pull-up, so a released line reads high
  always_comb begin
    for (int i = 0; i < 9; i++) begin
      pin_i[i] = pin_oe[i] ? pin_o[i] : 1'b1;
    end
  end
endmodule

/* File: verification/gpp_port_bench.sv */
`timescale 1ns/1ns
module gpp_port_bench;
  import gpp_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, role;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0]  htrans, hresp;
  logic [2:0]  hsize, fext;
  logic [3:0]  pwm;
  logic [8:0]  gi, go, goe;
  int          mismatches, n_tests;
  gpp_port uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .role_select_pin(role),
    .pwm_in(pwm), .gpio_i(gi), .gpio_o(go), .gpio_oe(goe), .flash_addr_ext(fext));
  gpp_board brd (.pin_o(go), .pin_oe(goe), .pin_i(gi));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task automatic wrap_up;
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // single word transfer; the read data is taken at the data-phase edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k = 0;
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && k < 40) begin
      @(posedge hclk);
      k++;
    end
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && k < 40) begin
      @(posedge hclk);
      k++;
    end
    rv = hrdata;
    check(hresp, 32'h0);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      wrap_up;
    end
  endtask
  task automatic t_modes;
    logic [8:0] oe_tab [4] = '{9'h0, 9'h1ff, 9'h0f0, 9'h15a};
    logic [8:0] pin_tab [4] = '{9'h1ff, 9'h0a5, 9'h1af, 9'h0a5};
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, GPP_OFS_MODE, {14'h0, {9{m[1:0]}}});
      bus(1'b1, GPP_OFS_DOUT, 32'h0a5);
      bus(1'b1, GPP_OFS_DRV, 32'h0f0);
      repeat (2) @(posedge hclk);
      check(goe, oe_tab[m]);
      if (m == 3) check(go, 32'h0);
      if (m == 1 || m == 2) check(go, 32'h0a5);
      // released pins come back through the pull-ups
      bus(1'b0, GPP_OFS_PIN, 32'h0);
      check(rv, pin_tab[m]);
    end
  endtask
  task automatic t_alt;
    pwm <= 4'ha;
    bus(1'b1, GPP_OFS_MODE, 32'h0);
    bus(1'b1, GPP_OFS_ALT, 32'h1ff);
    bus(1'b0, GPP_OFS_ALT, 32'h0);
    check(rv, 32'h0f);
    check(goe, 32'h00f);
    check(go[3:0], 32'ha);
    pwm <= 4'h5;
    repeat (3) @(posedge hclk);
    check(go[3:0], 32'h5);
  endtask
  task automatic t_flash;
    for (int v = 0; v < 8; v++) begin
      bus(1'b1, GPP_OFS_FEXT, v);
      @(posedge hclk);
      check(fext, v);
      bus(1'b0, GPP_OFS_FEXT, 32'h0);
      check(rv, v);
    end
  endtask
  task automatic t_role;
    bus(1'b1, GPP_OFS_MODE, 32'h15555);
    role <= 1'b0;
    repeat (4) @(posedge hclk);
    check(goe, 32'h0);
    bus(1'b0, GPP_OFS_STAT, 32'h0);
    check(rv, 32'h0);
    check(fext, 32'h7);
    role <= 1'b1;
    repeat (4) @(posedge hclk);
    check(goe, 32'h1ff);
    bus(1'b0, GPP_OFS_STAT, 32'h0);
    check(rv, 32'h1);
    // non-word transfers are ignored: the write is dropped, the read gives 0
    hsize <= 3'h0;
    bus(1'b1, GPP_OFS_FEXT, 32'h0);
    bus(1'b0, GPP_OFS_MODE, 32'h0);
    check(rv, 32'h0);
    hsize <= GPP_HSIZE_WORD;
    bus(1'b0, GPP_OFS_FEXT, 32'h0);
    check(rv, 32'h7);
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = GPP_HSIZE_WORD;
    hwdata = 32'h0;
    role = 1'b1;
    pwm = 4'h0;
    mismatches = 0;
    n_tests = 0;
    repeat (12) @(posedge hclk);
    check(goe, 32'h0);
    hresetn <= 1'b1;
    bus(1'b0, GPP_OFS_MODE, 32'h0);
    check(rv, 32'h0);
    bus(1'b0, 8'h40, 32'h0);
    check(rv, 32'h0);
    t_modes();
    t_alt();
    t_flash();
    t_role();
    hresetn <= 1'b0;
    @(posedge hclk);
    check(goe, 32'h0);
    check(fext, 32'h0);
    hresetn <= 1'b1;
    bus(1'b0, GPP_OFS_MODE, 32'h0);
    check(rv, 32'h0);
    check(goe, 32'h0);
    wrap_up();
  end
endmodule
